// file: src/swl_host.sv
// host end: APB-programmed serial master that loads wiper words
`timescale 1ns/1ps
module swl_host (
   // system
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link
   swl_link_if.host         link
);
   import swl_pkg::*;

   swl_state_t           state_q;
   logic [WORD_BITS-1:0] tx_q;
   logic [WORD_BITS-1:0] rx_q;
   logic [3:0]           half_q;
   logic [3:0]           bit_q;
   logic [31:0]          ctrl_q;
   logic                 sdoMeta_q;
   logic                 sdoSync_q;
   logic                 sclk_q;
   logic                 csN_q;
   logic                 sdi_q;
   logic                 apbWr;
   logic                 apbRd;
   logic                 startTx;
   logic                 halfEnd;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == REG_TXWORD) || (a == REG_STATUS) || (a == REG_CTRL);
   endfunction

   assign apbWr   = psel && penable && pwrite;
   assign apbRd   = psel && penable && !pwrite;
   // a word written while busy is dropped
   assign startTx = apbWr && (paddr == REG_TXWORD) && (state_q == SWL_IDLE);
   assign halfEnd = (half_q == HALF_LAST);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RESET_VAL;
      end else if (apbWr && paddr == REG_CTRL) begin
         ctrl_q <= pwdata;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
         prdata  <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               REG_TXWORD: prdata <= 32'(tx_q);
               REG_STATUS: prdata <= (32'(rx_q) << ST_RX_LSB)
                                     | (32'(state_q != SWL_IDLE) << ST_BUSY);
               REG_CTRL:   prdata <= ctrl_q;
               default:    prdata <= '0;
            endcase
         end
      end
   end

   // serial output from the device domain: two flops before use
   always_ff @(posedge clock) begin
      sdoMeta_q <= link.serialOutLine;
      sdoSync_q <= sdoMeta_q;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= SWL_IDLE;
         half_q  <= '0;
         bit_q   <= '0;
         tx_q    <= '0;
         rx_q    <= '0;
         sclk_q  <= 1'b0;
         csN_q   <= 1'b1;
         sdi_q   <= 1'b0;
      end else begin
         case (state_q)
            SWL_IDLE: begin
               sclk_q <= 1'b0;
               csN_q  <= 1'b1;
               if (startTx) begin
                  tx_q    <= pwdata[WORD_BITS-1:0];
                  csN_q   <= 1'b0;
                  sdi_q   <= pwdata[WORD_BITS-1];
                  bit_q   <= '0;
                  half_q  <= '0;
                  state_q <= SWL_LOW;
               end
            end
            SWL_LOW: begin
               half_q <= halfEnd ? 4'h0 : half_q + 4'h1;
               if (halfEnd) begin
                  sclk_q  <= 1'b1;
                  state_q <= SWL_HIGH;
               end
            end
            SWL_HIGH: begin
               half_q <= halfEnd ? 4'h0 : half_q + 4'h1;
               if (halfEnd) begin
                  sclk_q <= 1'b0;
                  rx_q   <= {rx_q[WORD_BITS-2:0], sdoSync_q};
                  if (bit_q == BIT_LAST) begin
                     state_q <= SWL_DONE;
                  end else begin
                     bit_q   <= bit_q + 4'h1;
                     tx_q    <= {tx_q[WORD_BITS-2:0], 1'b0};
                     sdi_q   <= tx_q[WORD_BITS-2];
                     state_q <= SWL_LOW;
                  end
               end
            end
            SWL_DONE: begin
               half_q <= halfEnd ? 4'h0 : half_q + 4'h1;
               if (halfEnd) begin
                  csN_q   <= 1'b1;
                  state_q <= SWL_IDLE;
               end
            end
            default: state_q <= SWL_IDLE;
         endcase
      end
   end

   assign link.linkClk        = sclk_q;
   assign link.csN            = csN_q;
   assign link.serialInLine   = sdi_q;
   assign link.midscaleResetN = !ctrl_q[CTRL_RESET];
   assign link.powerDownN     = !ctrl_q[CTRL_POWER_DOWN_N];
endmodule

// file: src/swl_pkg.sv
// shared constants for the serial wiper latch loader, device and host ends
// Functional notes
// - one update is exactly ten serial bits
// - two channel bits, then eight code bits, MSB first
// - code goes to latch chosen by address
// - host sends zero address bits on smaller variants
// - one word per channel, any order
// - shift clock at most 10 MHz
// - no power-up preset of wiper latches
// - midscale reset loads code 128 everywhere
// - shutdown opens A, ties wiper to B
// - shutdown keeps latch contents
// - shutdown keeps loading words, disables serial output
// - codes written in shutdown apply on release
// - code selects one of 256 taps, 00 at B
// - chip select low: shift in on rising clock
// - chip select rise loads addressed latch
// - bit entered ten edges earlier leaves serial output
// - midscale reset also clears serial output latch
package swl_pkg;
   localparam int          WORD_BITS  = 10;
   localparam int          CODE_BITS  = 8;
   localparam int          ADDR_BITS  = 2;
   localparam int          CHANNELS   = 4;
   localparam logic [7:0]  MIDSCALE   = 8'h80;
   // host register map, one aligned 32-bit word each
   localparam logic [7:0]  REG_TXWORD = 8'h00;
   localparam logic [7:0]  REG_STATUS = 8'h04;
   localparam logic [7:0]  REG_CTRL   = 8'h08;
   localparam int          ST_BUSY    = 0;
   localparam int          ST_RX_LSB  = 16;
   localparam int          CTRL_RESET = 0;
   localparam int          CTRL_POWER_DOWN_N  = 1;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
   // timing
   localparam int          CLK_MHZ         = 25;
   localparam int          SCLK_MAX_MHZ    = 10;
   localparam int          SCLK_MIN_HALF_NS = 1000 / (2 * SCLK_MAX_MHZ);
   // one cycle beyond the least half period lets the synchronised serial output settle
   localparam int          SCLK_HALF_CYC   = (SCLK_MIN_HALF_NS * CLK_MHZ + 999) / 1000 + 1;
   localparam logic [3:0]  HALF_LAST  = 4'(SCLK_HALF_CYC - 1);
   localparam logic [3:0]  BIT_LAST   = 4'(WORD_BITS - 1);
   typedef logic [CODE_BITS-1:0] swl_code_t;
   typedef enum logic [3:0] {
      SWL_IDLE = 4'b0001,
      SWL_LOW  = 4'b0010,
      SWL_HIGH = 4'b0100,
      SWL_DONE = 4'b1000
   } swl_state_t;
endpackage

// file: src/swl_link_if.sv
// link between host and wiper device: serial lines and control pins
`timescale 1ns/1ps
interface swl_link_if;
   logic linkClk;
   logic csN;
   logic serialInLine;
   logic midscaleResetN;
   logic powerDownN;
   logic serialOutO;
   logic serialOutOe;
   logic serialOutLine;
   // open drain with pull-up
   assign serialOutLine = serialOutOe ? serialOutO : 1'b1;
   modport device (
      input  linkClk, csN, serialInLine, midscaleResetN, powerDownN,
      output serialOutO, serialOutOe
   );
   modport host (
      output linkClk, csN, serialInLine, midscaleResetN, powerDownN,
      input  serialOutLine
   );
endinterface

// file: src/swl_device.sv
// wiper device end: shift register, address decode and wiper latches
`timescale 1ns/1ps
module swl_device (
   // link
   swl_link_if.device                    link,
   // wiper state
   output swl_pkg::swl_code_t            wiperCode [swl_pkg::CHANNELS],
   output logic                          terminalAOpen,
   output logic                          wiperToB
);
   import swl_pkg::*;

   logic [WORD_BITS-1:0] shift_q;
   logic                 sdoLatch_q;
   logic [ADDR_BITS-1:0] chanSel;
   swl_code_t            latch_q [CHANNELS];

   // shift runs on the link clock only while selected
   always_ff @(posedge link.linkClk or negedge link.midscaleResetN) begin
      if (!link.midscaleResetN) begin
         shift_q    <= '0;
         sdoLatch_q <= 1'b0;
      end else if (!link.csN) begin
         shift_q    <= {shift_q[WORD_BITS-2:0], link.serialInLine};
         sdoLatch_q <= shift_q[WORD_BITS-1];
      end
   end

   assign chanSel = shift_q[WORD_BITS-1 -: ADDR_BITS];

   // latches are clocked by the chip select rise; no preset without reset
   generate
      for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_latch
         always_ff @(posedge link.csN or negedge link.midscaleResetN) begin
            if (!link.midscaleResetN) begin
               latch_q[ch] <= MIDSCALE;
            end else if (chanSel == ADDR_BITS'(ch)) begin
               latch_q[ch] <= shift_q[CODE_BITS-1:0];
            end
         end
         // code 00 is the B end tap, each step one tap toward A; shutdown only
         // gates the analog switches and serial output, so stored codes reappear on release
         assign wiperCode[ch] = latch_q[ch];
      end
   endgenerate

   assign terminalAOpen = !link.powerDownN;
   assign wiperToB      = !link.powerDownN;

   // open drain: pulls low only for a zero, off in shutdown
   assign link.serialOutO  = 1'b0;
   assign link.serialOutOe = !sdoLatch_q && link.powerDownN && !link.csN;
endmodule

// file: sim/swl_chk.sv
// link checker: framing, clock rate, shift-out and shutdown
`timescale 1ns/1ps
module swl_chk (
   // link
   input wire logic linkClk,
   input wire logic csN,
   input wire logic serialInLine,
   input wire logic midscaleResetN,
   input wire logic powerDownN,
   input wire logic serialOutOe,
   input wire logic serialOutLine
);
   logic [3:0] bitCnt;
   logic [3:0] shiftCnt;
   realtime    lastRise;
   always_ff @(posedge linkClk or posedge csN)
      if (csN) bitCnt <= 4'h0;
      else bitCnt <= bitCnt + 4'h1;
   // saturates once the output latch holds a bit entered since reset: the bit
   // leaves the register ten edges after entry and is seen one edge later
   always_ff @(posedge linkClk or negedge midscaleResetN)
      if (!midscaleResetN) shiftCnt <= 4'h0;
      else if (shiftCnt != 4'hb) shiftCnt <= shiftCnt + 4'h1;
   always_ff @(posedge linkClk)
      lastRise <= $realtime;
   sequence s_idle;
      !linkClk;
   endsequence
   property p_word_len;
      @(posedge csN) disable iff (!midscaleResetN) (bitCnt != 4'h0) |-> bitCnt == 4'ha ##0 s_idle;
   endproperty
   property p_bit_bound;
      @(posedge linkClk) disable iff (!midscaleResetN) bitCnt < 4'ha;
   endproperty
   property p_in_frame;
      @(posedge linkClk) disable iff (!midscaleResetN) !csN;
   endproperty
   property p_cs_fall;
      @(negedge csN) disable iff (!midscaleResetN) s_idle;
   endproperty
   property p_rate;
      @(posedge linkClk) disable iff (!midscaleResetN)
         (bitCnt != 4'h0) |-> ($realtime - lastRise) >= 100.0;
   endproperty
   property p_shift_out;
      @(posedge linkClk) disable iff (!midscaleResetN)
         (shiftCnt == 4'hb && powerDownN) |-> serialOutLine == $past(serialInLine, 11);
   endproperty
   property p_rst_clr;
      @(posedge linkClk) disable iff (!midscaleResetN)
         (shiftCnt != 4'hb && powerDownN) |-> !serialOutLine;
   endproperty
   property p_power_down_n;
      @(posedge linkClk) disable iff (!midscaleResetN) !powerDownN |-> !serialOutOe;
   endproperty
   a_word_len: assert property (p_word_len) else $error("bad frame length");
   a_bit_bound: assert property (p_bit_bound) else $error("too many clocks");
   a_in_frame: assert property (p_in_frame) else $error("clock outside frame");
   a_cs_fall: assert property (p_cs_fall) else $error("clock high at select");
   a_rate: assert property (p_rate) else $error("link clock too fast");
   a_shift_out: assert property (p_shift_out) else $error("bad shifted bit");
   a_rst_clr: assert property (p_rst_clr) else $error("output not cleared");
   a_power_down_n: assert property (p_power_down_n) else $error("output on in shutdown");
endmodule

// file: sim/serial_wiper_latch_loader_test.sv
// bench: host and wiper device back to back, driven over apb
`timescale 1ns/1ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module serial_wiper_latch_loader_test;
   import swl_pkg::*;
   logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   swl_code_t   wiperCode [CHANNELS];
   swl_code_t   expCode [CHANNELS];
   logic        terminalAOpen, wiperToB;
   int          n_errors = 0;
   int          checked = 0;
   int          cyc = 0;
   swl_link_if link ();
   swl_host swl_host_inst (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.host));
   swl_device swl_device_inst (.link(link.device), .wiperCode(wiperCode),
      .terminalAOpen(terminalAOpen), .wiperToB(wiperToB));
   swl_chk swl_chk_inst (.linkClk(link.linkClk), .csN(link.csN),
      .serialInLine(link.serialInLine), .midscaleResetN(link.midscaleResetN),
      .powerDownN(link.powerDownN), .serialOutOe(link.serialOutOe),
      .serialOutLine(link.serialOutLine));
   task automatic final_report();
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      // no limit of its own: ends once pready is seen high, else at the bench timeout
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never drives psel twice at one edge
      @(posedge clock);
   endtask
   // serial output seen over the last frame: previous word, all ones in shutdown
   function automatic logic [9:0] exp_rx(input logic shut, input logic [9:0] last);
      return shut ? 10'h3ff : last;
   endfunction
   // polls busy; the word has landed in its latch once busy drops
   task automatic send(input logic [1:0] ch, input swl_code_t c);
      apb(1'b1, REG_TXWORD, {22'h0, ch, c});
      rd = 32'h1;
      while (rd[ST_BUSY] !== 1'b0) begin
         apb(1'b0, REG_STATUS, 32'h0);
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      logic [9:0] prev;
      logic [1:0] ch;
      swl_code_t  c;
      logic       sd;
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
      void'($urandom(32'h0f89));
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      apb(1'b0, 8'h0c, 32'h0);
      `CMP({err, rd}, {1'b1, 32'h0})
      for (int i = 0; i < 28; i++) begin
         if (i == 0 || i == 20) begin
            apb(1'b1, REG_CTRL, 32'h1);
            apb(1'b1, REG_CTRL, 32'h0);
            expCode = '{default: MIDSCALE};
            prev = 10'h0;
            for (int k = 0; k < CHANNELS; k++) `CMP(wiperCode[k], MIDSCALE)
         end
         if (i == 12 || i == 18) begin
            apb(1'b1, REG_CTRL, {30'h0, i == 12, 1'b0});
            apb(1'b0, REG_CTRL, 32'h0);
            `CMP(rd, {30'h0, i == 12, 1'b0})
         end
         sd = (i >= 12 && i < 18);
         // four-channel build: every address pattern is legal
         ch = (i < 8) ? i[1:0] : 2'($urandom);
         c = (i < 4) ? 8'h00 : (i < 8) ? 8'hff : 8'($urandom);
         send(ch, c);
         expCode[ch] = c;
         `CMP(rd[25:16], exp_rx(sd, prev))
         prev = {ch, c};
         `CMP({terminalAOpen, wiperToB}, {sd, sd})
         for (int k = 0; k < CHANNELS; k++) `CMP(wiperCode[k], expCode[k])
      end
      final_report();
   end
endmodule
